// ### balance_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none

module balance_tick_gen
  import cell_balance_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  output logic tick
);

  localparam int CNT_W = (TICK_CYCLES_P > 1) ? $clog2(TICK_CYCLES_P) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TICK_CYCLES_P - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } tick_state_t;

  tick_state_t st_r;
  tick_state_t st_nxt;

  generate
    if (TICK_CYCLES_P < 1) begin : g_bad_period
      $error("tick period must be at least one cycle");
    end
  endgenerate

  // one-cycle pulse every TICK_CYCLES_P clocks
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == CNT_LAST) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + CNT_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule : balance_tick_gen

`default_nettype wire

// ### cell_balance_pkg.sv
package cell_balance_pkg;

  // bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int IDX_W = 14;
  localparam int BYTE_SHIFT = 2;

  // timer register layout
  localparam int COUNT_W = 14;
  localparam int COUNT_LSB = 0;
  localparam int COUNT_MSB = 13;
  localparam int RSVD_LSB = 14;
  localparam int RSVD_MSB = 15;
  localparam int LOW_BYTE_MSB = 7;
  localparam int HIGH_BYTE_LSB = 8;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 14'h0000;
  localparam logic [COUNT_W-1:0] countdown_finished_value = 14'h0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 14'h3fff;
  localparam logic [COUNT_W-1:0] COUNT_STEP = 14'h0001;

  // timing
  localparam int TICK_PERIOD_S = 10;
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_S * CLK_HZ;
  localparam int MAX_BALANCE_S = 163830;

  // register indices; byte address is index shifted by BYTE_SHIFT
  localparam logic [IDX_W-1:0] TIMER_BASE_IDX = 14'h1020;
  localparam logic [IDX_W-1:0] BALANCE_TIMER_CH2_IDX = 14'h1022;
  localparam logic [IDX_W-1:0] BALANCE_TIMER_CH3_IDX = 14'h1023;
  localparam logic [IDX_W-1:0] BALANCE_TIMER_CH4_IDX = 14'h1024;
  localparam logic [IDX_W-1:0] BALANCE_CTRL_IDX = 14'h1030;
  localparam logic [IDX_W-1:0] BALANCE_STATUS_IDX = 14'h1031;

  // control register fields
  localparam int CTRL_GLOBAL_BIT = 0;
  localparam int CTRL_TIMER_MODE_BIT = 1;
  localparam int CTRL_CH_EN_LSB = 2;

  // status register fields
  localparam int STAT_ACTIVE_LSB = 0;
  localparam int STAT_FINISHED_LSB = 8;

  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0] byteenable;
  } avmm_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } avmm_rsp_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage : cell_balance_pkg

// ### cell_balance_timers.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - each channel owns a 14-bit read/write countdown in bits 13:0
// - reads return the live remaining count, not the written value
// - countdown stops at zero and never wraps
// - a zero count switches balancing off on that channel
// - count decrements only with global, timer mode and channel enable all set
// - one count unit equals ten seconds of balancing
// - full-scale count 3fff gives 163830 seconds
// - bits 15:14 are reserved, read-only, always zero
// - every count resets to zero, the finished state
// - channels 2, 3 and 4 sit at consecutive register indices
// - channel n sits at the series base index plus n
module cell_balance_timers
  import cell_balance_pkg::*;
#(
  parameter int FIRST_CH = 2,
  parameter int NUM_CH = 3,
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire avmm_req_t avmm_req,
  output avmm_rsp_t avmm_rsp,
  output logic [NUM_CH-1:0] balance_allow,
  output logic [NUM_CH-1:0] balance_active
);

  localparam int CH_LIMIT = 6;
  localparam int MAX_SECONDS_CALC = int'(COUNT_MAX) * TICK_PERIOD_S;

  generate
    if (NUM_CH < 1 || NUM_CH > CH_LIMIT) begin : g_bad_count
      $error("channel count must lie between 1 and 6");
    end
    if (FIRST_CH < 0 || FIRST_CH + NUM_CH > 2 ** (IDX_W - 6)) begin : g_bad_first
      $error("channel numbering leaves the timer series");
    end
    if (MAX_SECONDS_CALC != MAX_BALANCE_S) begin : g_bad_scale
      $error("full-scale count does not match the longest balancing time");
    end
  endgenerate

  typedef struct packed {
    bus_state_t bus;
    logic [DATA_W-1:0] readdata;
    logic global_en;
    logic timer_mode_en;
    logic [NUM_CH-1:0] ch_en;
    logic [NUM_CH-1:0][COUNT_W-1:0] count;
    logic [NUM_CH-1:0] allow;
    logic [NUM_CH-1:0] active;
  } timer_state_t;

  timer_state_t st_r;
  timer_state_t st_nxt;

  logic tick;
  logic [IDX_W-1:0] req_idx;
  logic [NUM_CH-1:0] ch_hit;
  logic [NUM_CH-1:0] may_count;
  logic ctrl_hit;
  logic status_hit;
  logic timer_hit;

  balance_tick_gen #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
  ) u_tick (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // byte address to register index
  function automatic logic [IDX_W-1:0] addr_to_idx(input logic [ADDR_W-1:0] addr);
    addr_to_idx = addr[ADDR_W-1:BYTE_SHIFT];
  endfunction : addr_to_idx

  // index of timer channel n within the series
  function automatic logic [IDX_W-1:0] chan_idx(input int n);
    chan_idx = TIMER_BASE_IDX + IDX_W'(n);
  endfunction : chan_idx

  // timer word with reserved bits forced low
  function automatic logic [DATA_W-1:0] timer_word(input logic [COUNT_W-1:0] cnt);
    timer_word = READ_ZERO;
    timer_word[COUNT_MSB:COUNT_LSB] = cnt;
  endfunction : timer_word

  // byte-lane merge of a write into a count
  function automatic logic [COUNT_W-1:0] merge_count(
    input logic [COUNT_W-1:0] old_cnt,
    input logic [DATA_W-1:0] wdata,
    input logic [BE_W-1:0] be
  );
    merge_count = old_cnt;
    if (be[0]) begin
      merge_count[LOW_BYTE_MSB:COUNT_LSB] = wdata[LOW_BYTE_MSB:COUNT_LSB];
    end
    if (be[1]) begin
      merge_count[COUNT_MSB:HIGH_BYTE_LSB] = wdata[COUNT_MSB:HIGH_BYTE_LSB];
    end
  endfunction : merge_count

  assign req_idx = addr_to_idx(avmm_req.address);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_decode
      assign ch_hit[gi] = (req_idx == chan_idx(FIRST_CH + gi));
      assign may_count[gi] = st_r.global_en & st_r.timer_mode_en & st_r.ch_en[gi];
    end
  endgenerate

  assign ctrl_hit = (req_idx == BALANCE_CTRL_IDX);
  assign status_hit = (req_idx == BALANCE_STATUS_IDX);
  assign timer_hit = |ch_hit;

  // read multiplexer for the word captured on acceptance
  function automatic logic [DATA_W-1:0] read_word(
    input timer_state_t s,
    input logic [NUM_CH-1:0] hits,
    input logic c_hit,
    input logic s_hit
  );
    read_word = READ_ZERO;
    for (int i = 0; i < NUM_CH; i++) begin
      if (hits[i]) begin
        read_word = timer_word(s.count[i]);
      end
    end
    if (c_hit) begin
      read_word[CTRL_GLOBAL_BIT] = s.global_en;
      read_word[CTRL_TIMER_MODE_BIT] = s.timer_mode_en;
      read_word[CTRL_CH_EN_LSB +: NUM_CH] = s.ch_en;
    end
    if (s_hit) begin
      read_word[STAT_ACTIVE_LSB +: NUM_CH] = s.active;
      read_word[STAT_FINISHED_LSB +: NUM_CH] = ~s.allow;
    end
  endfunction : read_word

  always_comb begin
    st_nxt = st_r;

    // countdown on the shared tick
    if (tick) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (may_count[i] && st_r.count[i] != countdown_finished_value) begin
          st_nxt.count[i] = st_r.count[i] - COUNT_STEP;
        end
      end
    end

    // bus slave: accept, then answer with waitrequest low for one cycle
    case (st_r.bus)
      BUS_IDLE: begin
        if (avmm_req.read || avmm_req.write) begin
          st_nxt.bus = BUS_ACK;
          if (avmm_req.read) begin
            st_nxt.readdata = read_word(st_r, ch_hit, ctrl_hit, status_hit);
          end else begin
            st_nxt.readdata = READ_ZERO;
          end
        end
      end
      BUS_ACK: begin
        st_nxt.bus = BUS_IDLE;
        if (avmm_req.write) begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (ch_hit[i]) begin
              // a write wins over a tick in the same cycle
              st_nxt.count[i] = merge_count(st_r.count[i], avmm_req.writedata,
                                            avmm_req.byteenable);
            end
          end
          if (ctrl_hit && avmm_req.byteenable[0]) begin
            st_nxt.global_en = avmm_req.writedata[CTRL_GLOBAL_BIT];
            st_nxt.timer_mode_en = avmm_req.writedata[CTRL_TIMER_MODE_BIT];
            st_nxt.ch_en = avmm_req.writedata[CTRL_CH_EN_LSB +: NUM_CH];
          end
        end
      end
      default: begin
        st_nxt.bus = BUS_IDLE;
      end
    endcase

    // balancing permission follows the count that will stand
    for (int i = 0; i < NUM_CH; i++) begin
      st_nxt.allow[i] = (st_nxt.count[i] != countdown_finished_value);
      st_nxt.active[i] = st_nxt.allow[i] & st_nxt.global_en & st_nxt.timer_mode_en
                         & st_nxt.ch_en[i];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r.bus <= BUS_IDLE;
      st_r.readdata <= READ_ZERO;
      st_r.global_en <= 1'b0;
      st_r.timer_mode_en <= 1'b0;
      st_r.ch_en <= '0;
      st_r.count <= {NUM_CH{COUNT_RESET}};
      st_r.allow <= '0;
      st_r.active <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avmm_rsp.waitrequest = (st_r.bus != BUS_ACK);
  assign avmm_rsp.readdata = st_r.readdata;
  assign balance_allow = st_r.allow;
  assign balance_active = st_r.active;

endmodule : cell_balance_timers

`default_nettype wire

// ### cell_balance_timers_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cell_balance_timers_sva
  import cell_balance_pkg::*;
#(parameter int NUM_CH = 3) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire avmm_req_t avmm_req,
  input wire avmm_rsp_t avmm_rsp,
  input wire logic [NUM_CH-1:0] balance_allow,
  input wire logic [NUM_CH-1:0] balance_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire logic ack = !avmm_rsp.waitrequest;
  wire logic req = avmm_req.read || avmm_req.write;
  wire logic wack = ack && avmm_req.write;
  a_ack_once: assert property (ack |=> !ack)
    else $error("ack held");
  a_ack_cause: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_req_answer: assert property (req && !ack |-> ##[1:2] ack)
    else $error("request not answered");
  a_rsvd_zero: assert property (ack |-> avmm_rsp.readdata[15:14] == 2'b00)
    else $error("reserved bits set");
  a_off_at_zero: assert property ((balance_active & ~balance_allow) == '0)
    else $error("active with zero count");
  a_allow_rise: assert property (
    |(balance_allow & ~$past(balance_allow)) |-> $past(wack))
    else $error("count rose without write");
  a_active_rise: assert property (
    |(balance_active & ~$past(balance_active)) |-> $past(wack))
    else $error("active rose without write");
  a_ch0_empty: assert property (
    ack && avmm_req.read && avmm_req.address == 16'h4080 |-> avmm_rsp.readdata == '0)
    else $error("channel 0 word not empty");
  c_read: cover property (ack && avmm_req.read);
  c_write: cover property (wack);
  c_active: cover property (|balance_active);
endmodule : cell_balance_timers_sva
bind cell_balance_timers cell_balance_timers_sva #(.NUM_CH(NUM_CH)) u_sva (
  .core_clk(core_clk), .sys_rst(sys_rst), .avmm_req(avmm_req), .avmm_rsp(avmm_rsp),
  .balance_allow(balance_allow), .balance_active(balance_active));
`default_nettype wire

// ### cell_balance_timers_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module cell_balance_timers_tb
  import cell_balance_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  avmm_req_t req = '0;
  avmm_rsp_t rsp;
  logic [2:0] allow;
  logic [2:0] active;
  logic [31:0] rd;
  int mismatches = 0;
  int n_tests = 0;
  always #50 core_clk = ~core_clk;
  cell_balance_timers #(.TICK_CYCLES_P(8)) dut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .avmm_req(req),
    .avmm_rsp(rsp),
    .balance_allow(allow),
    .balance_active(active)
  );
  task automatic stop_test();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{a, ~wr, wr, d, 4'hf};
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50) mismatches++;
    rd = rsp.readdata;
    req <= '0;
    @(posedge core_clk);
  endtask : bus
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdchk
  task automatic t_reset();
    `CHK(allow, 3'b000)
    rdchk(16'h4088, 32'h0);
    rdchk(16'h408c, 32'h0);
    rdchk(16'h4090, 32'h0);
  endtask : t_reset
  task automatic t_regs();
    bus(1'b1, 16'h4088, 32'hffff_ffff);
    bus(1'b1, 16'h408c, 32'h0000_1234);
    bus(1'b1, 16'h4090, 32'h0000_0003);
    bus(1'b1, 16'h4080, 32'h0000_0005);
    repeat (30) @(posedge core_clk);
    rdchk(16'h4088, 32'h0000_3fff);
    rdchk(16'h408c, 32'h0000_1234);
    rdchk(16'h4090, 32'h0000_0003);
    rdchk(16'h4080, 32'h0);
    `CHK(allow, 3'b111)
    `CHK(active, 3'b000)
  endtask : t_regs
  task automatic t_count();
    logic [31:0] ctl [3];
    ctl = '{32'h0a, 32'h09, 32'h03};
    bus(1'b1, 16'h4088, 32'h3);
    bus(1'b1, 16'h40c0, 32'h17);
    `CHK(active, 3'b101)
    repeat (60) @(posedge core_clk);
    rdchk(16'h4088, 32'h0);
    rdchk(16'h4090, 32'h0);
    rdchk(16'h408c, 32'h1234);
    `CHK(allow, 3'b010)
    `CHK(active, 3'b000)
    bus(1'b1, 16'h40c0, 32'h0b);
    repeat (20) @(posedge core_clk);
    bus(1'b0, 16'h408c, 32'h0);
    `CHK(rd[13:0] < 14'h1234 && rd[13:0] > 14'h122c, 1'b1)
    foreach (ctl[i]) begin
      bus(1'b1, 16'h40c0, ctl[i]);
      bus(1'b1, 16'h408c, 32'h100);
      repeat (30) @(posedge core_clk);
      rdchk(16'h408c, 32'h100);
    end
  endtask : t_count
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_regs();
    t_count();
    sys_rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end
endmodule : cell_balance_timers_tb
`default_nettype wire
